// file: logic/led_drv_consts.vh
`ifndef LED_DRV_CONSTS_VH
`define LED_DRV_CONSTS_VH

// Number of ports and indicators
`define NUM_PORTS 4
`define IND_PER_PORT 6
`define FRAME_BITS 24
`define FRAME_CNT_W 5

// Indicator function select codes (2 bits per indicator)
`define SEL_W 2
// Field positions of a, b and c inside a port's configuration
`define A_LSB 0
`define B_LSB 2
`define C_LSB 4
// Indicator a: transmit, receive, link, duplex
`define A_SEL_TX 2'h0
`define A_SEL_RX 2'h1
`define A_SEL_LINK 2'h2
`define A_SEL_DUP 2'h3
// Indicator b: receive, link, duplex, speed
`define B_SEL_RX 2'h0
`define B_SEL_LINK 2'h1
`define B_SEL_DUP 2'h2
`define B_SEL_SPD 2'h3
// Indicator c: link, duplex, speed, collision
`define C_SEL_LINK 2'h0
`define C_SEL_DUP 2'h1
`define C_SEL_SPD 2'h2
`define C_SEL_COL 2'h3

// Reset value of the per-port configuration field {c,b,a}
`define CFG_W 6
`define CFG_RESET 6'h00

// Shift clock: 100 MHz system clock divided to 25 MHz
`define SYS_CLK_MHZ 100
`define SHIFT_CLK_MHZ 25
`define DIV_W 2
`define DIV_HALF ((`SYS_CLK_MHZ / `SHIFT_CLK_MHZ) / 2)

`endif

// file: logic/ind_select.v
`timescale 1ns/1ns
`include "led_drv_consts.vh"

// Picks the three indicator states of one port from its status bits
module ind_select (
  // Port status, active high
  input wire tx_act_i,
  input wire rx_act_i,
  input wire link_i,
  input wire duplex_i,
  input wire speed_i,
  input wire col_i,
  // Function selection {c,b,a}
  input wire [`CFG_W-1:0] cfg_i,
  // Selected states, high means lit
  output reg ind_a_o,
  output reg ind_b_o,
  output reg ind_c_o
);

  always @* begin
    case (cfg_i[`A_LSB +: `SEL_W])
      `A_SEL_TX: ind_a_o = tx_act_i; // RL2
      `A_SEL_RX: ind_a_o = rx_act_i; // RL3
      `A_SEL_LINK: ind_a_o = link_i; // RL3
      default: ind_a_o = duplex_i; // RL3
    endcase
    case (cfg_i[`B_LSB +: `SEL_W])
      `B_SEL_RX: ind_b_o = rx_act_i; // RL4
      `B_SEL_LINK: ind_b_o = link_i; // RL5
      `B_SEL_DUP: ind_b_o = duplex_i; // RL5
      default: ind_b_o = speed_i; // RL5
    endcase
    case (cfg_i[`C_LSB +: `SEL_W])
      `C_SEL_LINK: ind_c_o = link_i; // RL6
      `C_SEL_DUP: ind_c_o = duplex_i; // RL7
      `C_SEL_SPD: ind_c_o = speed_i; // RL7
      default: ind_c_o = col_i; // RL7
    endcase
  end

endmodule // ind_select

// file: logic/quad_port_led_indicator_driver.v
// Functional notes
// RL1: Each indicator pin is open drain, pulled low when lit, floating else.
// RL2: Indicator a of each port defaults to showing transmit activity.
// RL3: Indicator a can instead show receive, link or duplex.
// RL4: Indicator b of each port defaults to showing receive activity.
// RL5: Indicator b can instead show link, duplex or speed.
// RL6: Indicator c of each port defaults to showing link up.
// RL7: Indicator c can instead show duplex, speed or collision.
// RL8: Indicator states leave serially on one data pin, 24 bits per frame.
// RL9: A 25 MHz shift clock goes out with the serial data.
// RL10: A high qualifier marks valid serial data; the receiver uses only that.
// RL11: The system supplies a continuous reference clock.
// RL12: A writable per-port selection field resets to the default functions.
// RL13: Frames send bits port by port, one per clock, qualifier high 24 clocks.
`timescale 1ns/1ns
`include "led_drv_consts.vh"

module quad_port_led_indicator_driver #(
  parameter NPORT = `NUM_PORTS
) (
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RST_I,
  // Per-port status, one bit per port, from the PHY core
  input wire [NPORT-1:0] TX_ACT_I,
  input wire [NPORT-1:0] RX_ACT_I,
  input wire [NPORT-1:0] LINK_UP_I,
  input wire [NPORT-1:0] FULL_DUPLEX_I,
  input wire [NPORT-1:0] SPEED_100_I,
  input wire [NPORT-1:0] COLLISION_I,
  // Configuration: 6 bits per port {c,b,a}, written when CFG_WR_I is high
  input wire [NPORT*`CFG_W-1:0] CFG_WDATA_I,
  input wire CFG_WR_I,
  output wire [NPORT*`CFG_W-1:0] CFG_RDATA_O,
  // Open-drain indicators a, b, c per port: drive low while enable high
  output wire [NPORT-1:0] PORT_INDICATOR_A_O,
  output wire [NPORT-1:0] PORT_INDICATOR_A_OE_O,
  output wire [NPORT-1:0] PORT_INDICATOR_B_O,
  output wire [NPORT-1:0] PORT_INDICATOR_B_OE_O,
  output wire [NPORT-1:0] PORT_INDICATOR_C_O,
  output wire [NPORT-1:0] PORT_INDICATOR_C_OE_O,
  // Serial indicator link
  output reg SERIAL_INDICATOR_DATA_O,
  output reg SERIAL_INDICATOR_SHIFT_CLOCK_O,
  output reg SERIAL_INDICATOR_FRAME_VALID_O
);

  // Configuration and indicator state
  reg [NPORT*`CFG_W-1:0] cfg;
  reg [NPORT*`CFG_W-1:0] next_cfg;
  reg [NPORT-1:0] ind_a;
  reg [NPORT-1:0] ind_b;
  reg [NPORT-1:0] ind_c;
  wire [NPORT-1:0] sel_a;
  wire [NPORT-1:0] sel_b;
  wire [NPORT-1:0] sel_c;

  // Serial link state
  localparam ST_LOAD = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_GAP = 2'b10;
  wire [NPORT*`IND_PER_PORT-1:0] snap;
  reg [NPORT*`IND_PER_PORT-1:0] shreg;
  reg [`FRAME_CNT_W-1:0] bit_cnt;
  reg [1:0] state;
  reg [`DIV_W-1:0] div_cnt;
  wire fall;

  // Next values
  reg [NPORT*`IND_PER_PORT-1:0] next_shreg;
  reg [`FRAME_CNT_W-1:0] next_bit_cnt;
  reg [1:0] next_state;
  reg next_data;
  reg next_valid;
  reg [`DIV_W-1:0] next_div_cnt;
  reg next_shift_clock;

  // Configuration field
  // A write holds until the next; the readback is the live selection
  always @* begin
    if (CFG_WR_I) begin
      next_cfg = CFG_WDATA_I; // RL12
    end else begin
      next_cfg = cfg;
    end
  end
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      cfg <= {NPORT{`CFG_RESET}}; // RL12
    end else begin
      cfg <= next_cfg;
    end
  end
  assign CFG_RDATA_O = cfg;

  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : g_port
      ind_select u_sel (
        .tx_act_i(TX_ACT_I[p]),
        .rx_act_i(RX_ACT_I[p]),
        .link_i(LINK_UP_I[p]),
        .duplex_i(FULL_DUPLEX_I[p]),
        .speed_i(SPEED_100_I[p]),
        .col_i(COLLISION_I[p]),
        .cfg_i(cfg[p*`CFG_W +: `CFG_W]),
        .ind_a_o(sel_a[p]),
        .ind_b_o(sel_b[p]),
        .ind_c_o(sel_c[p])
      );
      // Six serial bits per port: a, b, c, then tx, rx, link raw
      assign snap[p*`IND_PER_PORT +: `IND_PER_PORT] =
        {LINK_UP_I[p], RX_ACT_I[p], TX_ACT_I[p],
         sel_c[p], sel_b[p], sel_a[p]}; // RL8
    end
  endgenerate

  // Registered indicator states
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ind_a <= {NPORT{1'b0}};
      ind_b <= {NPORT{1'b0}};
      ind_c <= {NPORT{1'b0}};
    end else begin
      ind_a <= sel_a;
      ind_b <= sel_b;
      ind_c <= sel_c;
    end
  end

  // Open drain: data always low, enable when lit
  assign PORT_INDICATOR_A_O = {NPORT{1'b0}}; // RL1
  assign PORT_INDICATOR_B_O = {NPORT{1'b0}}; // RL1
  assign PORT_INDICATOR_C_O = {NPORT{1'b0}}; // RL1
  assign PORT_INDICATOR_A_OE_O = ind_a; // RL1
  assign PORT_INDICATOR_B_OE_O = ind_b; // RL1
  assign PORT_INDICATOR_C_OE_O = ind_c; // RL1

  // Shift clock divider: 25 MHz, falling edge when fall is high
  // Data moves on the fall, giving the receiver half a period of setup
  assign fall = SERIAL_INDICATOR_SHIFT_CLOCK_O &&
                (div_cnt == `DIV_HALF - 1);
  always @* begin
    if (div_cnt == `DIV_HALF - 1) begin
      next_div_cnt = {`DIV_W{1'b0}};
      next_shift_clock = ~SERIAL_INDICATOR_SHIFT_CLOCK_O; // RL9
    end else begin
      next_div_cnt = div_cnt + 1'b1;
      next_shift_clock = SERIAL_INDICATOR_SHIFT_CLOCK_O;
    end
  end
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      div_cnt <= {`DIV_W{1'b0}};
      SERIAL_INDICATOR_SHIFT_CLOCK_O <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      SERIAL_INDICATOR_SHIFT_CLOCK_O <= next_shift_clock;
    end
  end

  // Frame steps advance only on a falling shift clock edge
  always @* begin
    next_state = state;
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_data = SERIAL_INDICATOR_DATA_O;
    next_valid = SERIAL_INDICATOR_FRAME_VALID_O;
    if (fall) begin
      case (state)
        ST_LOAD: begin
          // Status is caught once here, so no frame mixes two moments
          next_data = snap[0]; // RL13
          next_shreg = snap >> 1;
          next_valid = 1'b1; // RL10
          next_bit_cnt = {{(`FRAME_CNT_W-1){1'b0}}, 1'b1};
          next_state = ST_SHIFT;
        end
        ST_SHIFT: begin
          next_data = shreg[0]; // RL8
          next_shreg = shreg >> 1;
          next_bit_cnt = bit_cnt + 1'b1;
          if (bit_cnt == `FRAME_BITS - 1) begin
            // Last data bit of the frame: the gap follows
            next_state = ST_GAP;
          end
        end
        ST_GAP: begin
          // One idle shift clock with qualifier low between frames
          next_data = 1'b0;
          next_valid = 1'b0; // RL13
          next_bit_cnt = {`FRAME_CNT_W{1'b0}};
          next_state = ST_LOAD;
        end
        default: begin
          // Unknown step: idle the line and start over
          next_data = 1'b0;
          next_valid = 1'b0;
          next_bit_cnt = {`FRAME_CNT_W{1'b0}};
          next_state = ST_LOAD;
        end
      endcase
    end
  end

  // Serial registers: data and qualifier change on the falling shift edge
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state <= ST_LOAD;
      shreg <= {NPORT*`IND_PER_PORT{1'b0}};
      bit_cnt <= {`FRAME_CNT_W{1'b0}};
      SERIAL_INDICATOR_DATA_O <= 1'b0;
      SERIAL_INDICATOR_FRAME_VALID_O <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bit_cnt <= next_bit_cnt;
      SERIAL_INDICATOR_DATA_O <= next_data;
      SERIAL_INDICATOR_FRAME_VALID_O <= next_valid;
    end
  end

endmodule // quad_port_led_indicator_driver

// file: verif/led_drv_asserts.sv
`timescale 1ns/1ns
module led_drv_asserts (
  // Clock and reset
  input wire CLK_SYS_I,
  input wire RST_I,
  // Port status
  input wire [3:0] TX_ACT_I,
  input wire [3:0] RX_ACT_I,
  input wire [3:0] LINK_UP_I,
  input wire [3:0] FULL_DUPLEX_I,
  input wire [3:0] SPEED_100_I,
  input wire [3:0] COLLISION_I,
  // Configuration
  input wire [23:0] CFG_WDATA_I,
  input wire CFG_WR_I,
  input wire [23:0] CFG_RDATA_O,
  // Indicator pins
  input wire [3:0] PORT_INDICATOR_A_O,
  input wire [3:0] PORT_INDICATOR_B_O,
  input wire [3:0] PORT_INDICATOR_C_O,
  input wire [3:0] PORT_INDICATOR_A_OE_O,
  input wire [3:0] PORT_INDICATOR_B_OE_O,
  input wire [3:0] PORT_INDICATOR_C_OE_O,
  // Serial link
  input wire SERIAL_INDICATOR_DATA_O,
  input wire SERIAL_INDICATOR_SHIFT_CLOCK_O,
  input wire SERIAL_INDICATOR_FRAME_VALID_O
);
  wire [11:0] oe = {PORT_INDICATOR_C_OE_O, PORT_INDICATOR_B_OE_O,
    PORT_INDICATOR_A_OE_O};
  wire sck = SERIAL_INDICATOR_SHIFT_CLOCK_O;
  wire fv = SERIAL_INDICATOR_FRAME_VALID_O;
  reg [6:0] vc;
  // Cycles the qualifier has stood high in this frame
  always @(posedge CLK_SYS_I) vc <= (RST_I || !fv) ? 7'h00 : vc + 7'h01;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  sequence held(v);
    !$past(RST_I) && $past(CFG_RDATA_O) == v;
  endsequence
  sequence sck_rest;
    sck ##1 !sck [*2] ##1 sck;
  endsequence
  a_od_data: assert property (
    ~|{PORT_INDICATOR_A_O, PORT_INDICATOR_B_O, PORT_INDICATOR_C_O})
    else $error("open-drain data not low");
  a_cfg_load: assert property (
    CFG_WR_I |=> CFG_RDATA_O == $past(CFG_WDATA_I))
    else $error("config not loaded");
  a_dflt_map: assert property (
    held(24'h000000) |-> oe == {$past(LINK_UP_I), $past(RX_ACT_I),
    $past(TX_ACT_I)}) else $error("default indicator wrong");
  a_alt_map: assert property (
    held(24'hFFFFFF) |-> oe == {$past(COLLISION_I), $past(SPEED_100_I),
    $past(FULL_DUPLEX_I)}) else $error("alternate indicator wrong");
  a_mid_map: assert property (
    held(24'h555555) |-> oe == {$past(FULL_DUPLEX_I), $past(LINK_UP_I),
    $past(RX_ACT_I)}) else $error("second selection wrong");
  a_sck_shape: assert property (
    $rose(sck) |=> sck_rest) else $error("shift clock not 25 MHz");
  a_bit_align: assert property (
    !$fell(sck) |-> $stable({SERIAL_INDICATOR_DATA_O, fv}))
    else $error("serial line moved off clock fall");
  a_frame_len: assert property (
    $fell(fv) |-> vc == 7'h60 ##1 !fv [*3] ##1 fv)
    else $error("frame length or gap wrong");
endmodule // led_drv_asserts

// file: verif/led_sink_model.sv
`timescale 1ns/1ns
module led_sink_model (
  // Serial link
  input wire sck_i,
  input wire en_i,
  input wire dat_i,
  // Last whole frame; got toggles per frame
  output reg [23:0] frame_o,
  output reg got_o
);
  reg [23:0] sh;
  reg [4:0] n;
  initial begin
    n = 5'h00;
    got_o = 1'b0;
  end
  always @(posedge sck_i) begin
    if (en_i) begin
      sh <= {dat_i, sh[23:1]};
      n <= n + 5'h01;
    end else begin
      if (n == 5'h18) begin
        frame_o <= sh;
        got_o <= ~got_o;
      end
      n <= 5'h00;
    end
  end
endmodule // led_sink_model

// file: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  reg clk, rst, wr;
  reg [3:0] tx, rx, lk, dp, sp, cl;
  reg [23:0] wd, e;
  reg [11:0] x;
  reg [31:0] r;
  wire [23:0] rd, frame;
  wire [3:0] ao, bo, co;
  wire sd, sck, sv, got;
  integer bad_count, cmp_count, cyc, seed, t, i;
  quad_port_led_indicator_driver quad_port_led_indicator_driver_inst (
    .CLK_SYS_I(clk), .RST_I(rst), .TX_ACT_I(tx), .RX_ACT_I(rx),
    .LINK_UP_I(lk), .FULL_DUPLEX_I(dp), .SPEED_100_I(sp),
    .COLLISION_I(cl), .CFG_WDATA_I(wd), .CFG_WR_I(wr), .CFG_RDATA_O(rd),
    .PORT_INDICATOR_A_O(), .PORT_INDICATOR_A_OE_O(ao),
    .PORT_INDICATOR_B_O(), .PORT_INDICATOR_B_OE_O(bo),
    .PORT_INDICATOR_C_O(), .PORT_INDICATOR_C_OE_O(co),
    .SERIAL_INDICATOR_DATA_O(sd), .SERIAL_INDICATOR_SHIFT_CLOCK_O(sck),
    .SERIAL_INDICATOR_FRAME_VALID_O(sv));
  led_sink_model led_sink_model_inst (.sck_i(sck), .en_i(sv), .dat_i(sd),
    .frame_o(frame), .got_o(got));
  // Status k of a port is {col,spd,dup,link,rx,tx}[sel+k]
  function [23:0] expect_of(input [23:0] c);
    integer p, k;
    reg [5:0] s;
    begin
      for (p = 0; p < 4; p = p + 1) begin
        s = {cl[p], sp[p], dp[p], lk[p], rx[p], tx[p]};
        for (k = 0; k < 3; k = k + 1)
          expect_of[p*6+k] = s[c[p*6+2*k+:2]+k];
        expect_of[p*6+3+:3] = s[2:0];
      end
    end
  endfunction
  task chk(input [39:0] nm, input [23:0] seen, input [23:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      final_report;
    end
  end
  initial begin
    {bad_count, cmp_count, cyc} = 0;
    seed = 32'hDAF7;
    rst <= 1'b1;
    wr <= 1'b0;
    wd <= 24'h000000;
    {tx, rx, lk, dp, sp, cl} <= 24'h000000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Codes 0..3 on every indicator first, then random selections
    for (t = 0; t < 12; t = t + 1) begin
      @(posedge clk);
      r = $random(seed);
      wd <= (t < 4) ? {4{t[1:0], t[1:0], t[1:0]}} : r[23:0];
      wr <= 1'b1;
      r = $random(seed);
      {tx, rx, lk, dp, sp, cl} <= r[23:0];
      @(posedge clk);
      wr <= 1'b0;
      repeat (3) @(posedge clk);
      e = expect_of(wd);
      for (i = 0; i < 4; i = i + 1)
        {x[8+i], x[4+i], x[i]} = e[i*6+:3];
      chk("cfg", rd, wd);
      chk("oe", {co, bo, ao}, x);
      @(got);
      @(got);
      chk("frame", frame, e);
      $display("test %0d done", t);
    end
    final_report;
  end
endmodule // tb_top
bind quad_port_led_indicator_driver led_drv_asserts led_drv_asserts_inst (.*);
